/* dv/scsis_props.sv */
/* checker of the initiator sequencer port behaviour
   assumes one clock, rst active high, bound to scsis_seq */
`timescale 1ns/1ps
module scsis_props
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] tx_data,
	input wire logic [7:0] tx_bus_data,
	input wire logic tx_bus_par,
	input wire logic msg_valid,
	input wire scsis_pkg::scsis_msg_t msg,
	input wire logic [7:0] cmd_status,
	input wire logic [23:0] ccb_link_ptr,
	input wire logic sdtr_reply,
	input wire logic sdtr_start,
	input wire logic sel_done,
	input wire logic reject_out,
	input wire logic ccb_fetch,
	input wire logic [23:0] ccb_fetch_addr,
	input wire logic mbi_valid,
	input wire scsis_pkg::scsis_mbi_t mailbox_in_entry,
	input wire logic cmd_issue,
	input wire scsis_pkg::scsis_cmd_t cmd,
	input wire logic arb_req,
	input wire logic arb_won
);
	import scsis_pkg::*;
	logic known;
	// ====================
	// messages the sequencer understands
	assign known = msg.code[7] || (msg.code inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h0A, 8'h0B})
		|| (msg.code == 8'h01 && msg.ext <= 8'h01);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// fetch goes with an entry and the link address
	sequence s_fetch_ok;
		mbi_valid && ccb_fetch_addr == $past(ccb_link_ptr);
	endsequence
	sequence s_link_end;
		$past(msg_valid) && $past(msg.code) inside {8'h0A, 8'h0B};
	endsequence
	a_fetch_link: assert property (ccb_fetch |-> s_fetch_ok)
		else $error("fetch without entry or wrong address");
	a_fetch_cause: assert property (ccb_fetch |-> s_link_end)
		else $error("fetch without linked completion");
	a_mbi_status: assert property (mbi_valid |-> $past(msg_valid) && mailbox_in_entry.status == $past(cmd_status))
		else $error("entry status wrong");
	a_tx_odd: assert property (^{tx_bus_data, tx_bus_par} == 1'h1)
		else $error("bus parity not odd");
	a_tx_follow: assert property (!$past(rst) |-> tx_bus_data == $past(tx_data))
		else $error("bus data not one cycle behind");
	a_sdtr_reply: assert property (msg_valid && msg.code == 8'h01 && msg.ext == 8'h01 |=> sdtr_reply)
		else $error("negotiation not accepted");
	a_sdtr_cause: assert property (sdtr_start |-> $past(sel_done) || $past(sel_done, 2))
		else $error("negotiation start without selection");
	a_arb_drop: assert property (arb_req && arb_won |=> !arb_req)
		else $error("request held after win");
	a_reject_why: assert property (reject_out |-> $past(msg_valid && !known))
		else $error("reject of a known message");
	a_cmd_probe: assert property (cmd_issue |-> cmd.opcode == 8'h00)
		else $error("probe opcode wrong");
endmodule
bind scsis_seq scsis_props scsis_props_i (.clk(clk), .rst(rst), .tx_data(tx_data),
	.tx_bus_data(tx_bus_data), .tx_bus_par(tx_bus_par), .msg_valid(msg_valid), .msg(msg),
	.cmd_status(cmd_status), .ccb_link_ptr(ccb_link_ptr), .sdtr_reply(sdtr_reply),
	.sdtr_start(sdtr_start), .sel_done(sel_done), .reject_out(reject_out),
	.ccb_fetch(ccb_fetch), .ccb_fetch_addr(ccb_fetch_addr), .mbi_valid(mbi_valid), .mailbox_in_entry(mailbox_in_entry),
	.cmd_issue(cmd_issue), .cmd(cmd), .arb_req(arb_req), .arb_won(arb_won));

/* dv/scsis_tgt.sv */
/* target responder: arbitration, selection and probe answers
   assumes one clock, rst active high */
`timescale 1ns/1ps
module scsis_tgt
#(
	parameter logic [7:0] PRESENT = 8'h29,
	parameter int SLOW = 3
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic arb_req,
	input wire logic cmd_issue,
	input wire scsis_pkg::scsis_cmd_t cmd,
	output logic arb_won,
	output logic sel_done,
	output logic cmd_done,
	output logic cmd_ok
);
	import scsis_pkg::*;
	int cnt;
	int ccnt;
	logic [2:0] tgt;
	// ====================
	// wins after a delay, selection one cycle later
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			cnt <= 0;
			arb_won <= 1'h0;
			sel_done <= 1'h0;
		end
		else
		begin
			arb_won <= arb_req && !arb_won && cnt == SLOW;
			cnt <= (arb_req && cnt < SLOW) ? cnt + 1 : 0;
			sel_done <= arb_won;
		end
	// probe answer; ok line inverted outside the answer cycle
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			ccnt <= 0;
			tgt <= 3'h0;
			cmd_done <= 1'h0;
			cmd_ok <= 1'h0;
		end
		else
		begin
			if (cmd_issue)
				tgt <= cmd.target;
			ccnt <= cmd_issue ? SLOW : (ccnt > 0 ? ccnt - 1 : 0);
			cmd_done <= ccnt == 1;
			cmd_ok <= PRESENT[tgt] ^ (ccnt != 1);
		end
endmodule

/* dv/tb.sv */
/* self-checking bench of the initiator sequencer
   assumes the target responder and the bound checker */
`timescale 1ns/1ps
module tb;
	import scsis_pkg::*;
	logic clk, rst, reg_wr, reg_rd, irq, bus_rst_pin, arb_req, arb_won, sel_done;
	logic msg_valid, sdtr_reply, sdtr_start, reject_out, ccb_fetch, mbi_valid;
	logic cmd_issue, cmd_done, cmd_ok, rx_valid, rx_par, tx_bus_par;
	logic [3:0] reg_addr, pl;
	logic [31:0] reg_wdata, reg_rdata;
	logic [2:0] sel_target;
	logic [7:0] cmd_status, rx_data, tx_data, tx_bus_data;
	logic [23:0] ccb_fetch_addr, ccb_link_ptr;
	logic [8:0] pv [4] = '{9'h001, 9'h002, 9'h0FE, 9'h1FF}; // byte, then its odd parity bit
	scsis_msg_t msg;
	scsis_mbi_t mailbox_in_entry;
	scsis_cmd_t cmd;
	int mismatches, n_checks, n_start, i;
	scsis_seq scsis_seq_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.bus_rst_pin(bus_rst_pin), .arb_req(arb_req), .arb_won(arb_won),
		.sel_target(sel_target), .sel_done(sel_done), .msg_valid(msg_valid), .msg(msg),
		.cmd_status(cmd_status), .sdtr_reply(sdtr_reply), .sdtr_start(sdtr_start),
		.reject_out(reject_out), .ccb_fetch(ccb_fetch), .ccb_fetch_addr(ccb_fetch_addr),
		.ccb_link_ptr(ccb_link_ptr), .mbi_valid(mbi_valid), .mailbox_in_entry(mailbox_in_entry), .cmd_issue(cmd_issue),
		.cmd(cmd), .cmd_done(cmd_done), .cmd_ok(cmd_ok), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_par(rx_par), .tx_data(tx_data), .tx_bus_data(tx_bus_data),
		.tx_bus_par(tx_bus_par));
	scsis_tgt scsis_tgt_i (.clk(clk), .rst(rst), .arb_req(arb_req), .cmd_issue(cmd_issue),
		.cmd(cmd), .arb_won(arb_won), .sel_done(sel_done), .cmd_done(cmd_done), .cmd_ok(cmd_ok));
	// ====================
	// compare, register access and stimulus tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata, e);
	endtask
	task msg_tx(input logic [7:0] c, input logic [7:0] x, input logic [31:0] a);
		@(posedge clk);
		msg_valid <= 1'h1;
		msg <= {c, x, a};
		@(posedge clk);
		msg_valid <= 1'h0;
		#1 pl = {sdtr_reply, reject_out, ccb_fetch, mbi_valid};
	endtask
	task rx(input logic p);
		@(posedge clk);
		rx_valid <= 1'h1;
		rx_par <= p;
		@(posedge clk);
		rx_valid <= 1'h0;
	endtask
	task connect(input logic [31:0] blk, input logic [31:0] c);
		wr(4'h5, blk);
		wr(4'h0, c);
		i = 0;
		while (sel_done !== 1'h1 && i < 40)
		begin
			@(posedge clk);
			#1 i = i + 1;
		end
		chk(sel_done, 1'h1);
		chk(sel_target, blk[26:24]);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// clock
	initial
	begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	// counts negotiation starts
	always @(posedge clk)
		if (sdtr_start === 1'h1)
			n_start++;
	// watchdog
	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		final_report;
	end
	// main sequence
	initial
	begin
		{reg_wr, reg_rd, bus_rst_pin, msg_valid, rx_valid, rx_par} = '0;
		{reg_addr, reg_wdata, msg, cmd_status, rx_data, tx_data, ccb_link_ptr} = '0;
		rx_data = 8'h01;
		rst = 1'h1;
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		rd(4'h0, 32'h2);
		foreach (pv[k])
		begin
			@(posedge clk);
			tx_data <= pv[k][8:1];
			@(posedge clk);
			#1 chk({tx_bus_data, tx_bus_par}, pv[k]);
		end
		rx(1'h0);
		rd(4'h2, 32'h0);
		rx(1'h1);
		rd(4'h2, 32'h4);
		chk(irq, 1'h0);
		wr(4'h3, 32'h1F);
		#1 chk(irq, 1'h1);
		wr(4'h2, 32'h4);
		#1 chk(irq, 1'h0);
		wr(4'h0, 32'h0);
		rx(1'h1);
		rd(4'h2, 32'h0);
		connect(32'h03001000, 32'hA);
		ccb_link_ptr <= 24'h002000;
		cmd_status <= 8'h10;
		msg_tx(8'h01, 8'h00, 32'h100);
		msg_tx(8'h01, 8'h00, 32'hFFFFFFC0);
		rd(4'h4, 32'hC0);
		msg_tx(8'h02, 8'h00, 32'h0);
		rd(4'h7, 32'hC000);
		msg_tx(8'h0A, 8'h00, 32'h0);
		chk(pl, 4'h3);
		chk(ccb_fetch_addr, 24'h002000);
		chk(mailbox_in_entry, 32'h10001000);
		rd(4'h2, 32'h0);
		ccb_link_ptr <= 24'h003000;
		msg_tx(8'h0B, 8'h00, 32'h0);
		chk(mailbox_in_entry, 32'h10002000);
		rd(4'h2, 32'h1);
		wr(4'h2, 32'h1);
		ccb_link_ptr <= 24'h004000;
		msg_tx(8'h0A, 8'h00, 32'h0);
		rd(4'h1, 32'h13);
		chk(irq, 1'h0);
		msg_tx(8'h05, 8'h00, 32'h0);
		chk(pl, 4'h4);
		wr(4'h2, 32'h1F);
		cmd_status <= 8'h00;
		msg_tx(8'h00, 8'h00, 32'h0);
		chk(mailbox_in_entry, 32'h00004000);
		rd(4'h2, 32'h1);
		rd(4'h1, 32'h0);
		msg_tx(8'h01, 8'h01, 32'h0);
		chk(pl, 4'h8);
		connect(32'h05001000, 32'hE);
		repeat (3) @(posedge clk);
		chk(n_start, 1);
		msg_tx(8'h00, 8'h00, 32'h0);
		wr(4'h2, 32'h1F);
		@(posedge clk);
		bus_rst_pin <= 1'h1;
		repeat (4) @(posedge clk);
		bus_rst_pin <= 1'h0;
		repeat (4) @(posedge clk);
		rd(4'h2, 32'h2);
		rd(4'h0, 32'h6);
		wr(4'h0, 32'h7);
		rd(4'h1, 32'h0);
		rd(4'h4, 32'h0);
		rd(4'h0, 32'h6);
		wr(4'h2, 32'h2);
		wr(4'h0, 32'h2);
		wr(4'h0, 32'h12);
		i = 0;
		while (irq !== 1'h1 && i < 300)
		begin
			@(posedge clk);
			#1 i = i + 1;
		end
		rd(4'h2, 32'h10);
		rd(4'h6, 32'h29);
		rd(4'h8, 32'h0);
		final_report;
	end
endmodule

/* rtl/scsis_parity.sv */
/*
 * odd parity generation for bytes sent and checking for bytes received
 * assumes the caller registers the results
 */
`timescale 1ns/1ps
module scsis_parity
(
	input wire logic [7:0] tx_byte,
	input wire logic [7:0] rx_byte,
	input wire logic rx_par,
	input wire logic check_en,
	output logic tx_par,
	output logic rx_err
);
	// =====================================================================
	// parity is always produced, checking only when enabled
	assign tx_par = ~^tx_byte;
	assign rx_err = check_en & ~(^{rx_byte, rx_par});
endmodule

/* rtl/scsis_pkg.sv */
/*
 * types shared by the initiator sequencer files
 * assumes nothing beyond a SystemVerilog compiler
 */
package scsis_pkg;
	// =====================================================================
	// message from the target, already decoded by the phase engine
	typedef struct packed {
		logic [7:0] code;
		logic [7:0] ext;
		logic [31:0] arg;
	} scsis_msg_t;
	// mailbox-in entry: finished command status and block address
	typedef struct packed {
		logic [7:0] status;
		logic [23:0] addr;
	} scsis_mbi_t;
	// command issued to the bus
	typedef struct packed {
		logic [2:0] target;
		logic [7:0] opcode;
	} scsis_cmd_t;
	typedef enum logic [2:0] {
		SCSIS_IDLE = 3'b000,
		SCSIS_ARB = 3'b001,
		SCSIS_SEL = 3'b010,
		SCSIS_CONN = 3'b011,
		SCSIS_DISC = 3'b100,
		SCSIS_SCAN = 3'b101,
		SCSIS_SWAIT = 3'b110
	} scsis_state_t;
endpackage

/* rtl/scsis_regs.svh */
/*
 * register offsets, field positions, reset values and message codes of the
 * initiator sequencer; definitions only, included by the sequencer files
 */
`ifndef SCSIS_REGS_SVH
`define SCSIS_REGS_SVH
// =====================================================================
// register offsets on the plain register port
`define SCSIS_A_CTRL 4'h0
`define SCSIS_A_STATUS 4'h1
`define SCSIS_A_INT_STAT 4'h2
`define SCSIS_A_INT_MASK 4'h3
`define SCSIS_A_DPTR 4'h4
`define SCSIS_A_CCB 4'h5
`define SCSIS_A_SCAN 4'h6
`define SCSIS_A_NEG 4'h7
// =====================================================================
// control bits
`define SCSIS_C_SRST 0
`define SCSIS_C_PCHK 1
`define SCSIS_C_SYNC 2
`define SCSIS_C_START 3
`define SCSIS_C_SCAN 4
`define SCSIS_CTRL_W 3
`define SCSIS_CTRL_RST 3'h2
// =====================================================================
// interrupt status bits
`define SCSIS_I_MAILBOX_IN_FULL_INTERRUPT 0
`define SCSIS_I_BRST 1
`define SCSIS_I_PERR 2
`define SCSIS_I_REJ 3
`define SCSIS_I_SCAN 4
`define SCSIS_INT_W 5
// =====================================================================
// message codes and commands
`define SCSIS_M_CC 8'h00
`define SCSIS_M_EXT 8'h01
`define SCSIS_M_SDP 8'h02
`define SCSIS_M_DISC 8'h04
`define SCSIS_M_REJ 8'h07
`define SCSIS_M_LNK 8'h0A
`define SCSIS_M_LNKF 8'h0B
`define SCSIS_M_IDENT 7
`define SCSIS_X_MDP 8'h00
`define SCSIS_X_SDTR 8'h01
`define SCSIS_OP_TUR 8'h00
`define SCSIS_CCB_TGT 26:24
`define SCSIS_CCB_ADR 23:0
`endif

/* rtl/scsis_seq.sv */
/*
 * initiator sequencer of a bus-master scsi host adapter: arbitration and
 * selection, message handling, linked chains with mailbox-in posting,
 * data pointer adjustment, negotiation, reset handling and device scan.
 * assumes a phase engine that decodes messages and moves bytes, and a
 * memory engine that fetches command_control_blocks and writes entries.
 */
`timescale 1ns/1ps
`include "scsis_regs.svh"
module scsis_seq
#(
	parameter int TARGETS = 8
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic bus_rst_pin,
	output logic arb_req,
	input wire logic arb_won,
	output logic [2:0] sel_target,
	input wire logic sel_done,
	input wire logic msg_valid,
	input wire scsis_pkg::scsis_msg_t msg,
	input wire logic [7:0] cmd_status,
	output logic sdtr_reply,
	output logic sdtr_start,
	output logic reject_out,
	output logic ccb_fetch,
	output logic [23:0] ccb_fetch_addr,
	input wire logic [23:0] ccb_link_ptr,
	output logic mbi_valid,
	output scsis_pkg::scsis_mbi_t mailbox_in_entry,
	output logic cmd_issue,
	output scsis_pkg::scsis_cmd_t cmd,
	input wire logic cmd_done,
	input wire logic cmd_ok,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_par,
	input wire logic [7:0] tx_data,
	output logic [7:0] tx_bus_data,
	output logic tx_bus_par
);
	import scsis_pkg::*;

	// =====================================================================
	// state
	scsis_state_t state;
	logic [`SCSIS_CTRL_W-1:0] ctrl;
	logic [`SCSIS_INT_W-1:0] int_stat;
	logic [`SCSIS_INT_W-1:0] int_mask;
	logic [31:0] dptr;
	logic [31:0] saved_ptr;
	logic [26:0] ccb;
	logic [TARGETS-1:0] present;
	logic [TARGETS-1:0] negotiated;
	logic [2:0] scan_tgt;
	logic [2:0] rst_sync;
	logic bus_rst_lvl;
	logic chain_defer;
	logic [`SCSIS_INT_W-1:0] int_set;
	logic [`SCSIS_INT_W-1:0] int_clr;
	logic srst_req;
	logic start_req;
	logic scan_req;
	logic bus_rst_evt;
	logic par_gen;
	logic par_err;

	// register write decode, used by several processes
	function automatic logic wr_hit(input logic [3:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	// host strobes; a process, so strobe and index changes re-evaluate the decode
	always_comb
	begin
		srst_req = wr_hit(`SCSIS_A_CTRL) & reg_wdata[`SCSIS_C_SRST];
		start_req = wr_hit(`SCSIS_A_CTRL) & reg_wdata[`SCSIS_C_START];
		scan_req = wr_hit(`SCSIS_A_CTRL) & reg_wdata[`SCSIS_C_SCAN];
		int_clr = wr_hit(`SCSIS_A_INT_STAT) ? reg_wdata[`SCSIS_INT_W-1:0] : '0;
	end

	// =====================================================================
	// bus reset pin: three flops, change taken once last two agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rst_sync <= 3'h0;
			bus_rst_lvl <= 1'b0;
		end
		else
		begin
			rst_sync <= {rst_sync[1:0], bus_rst_pin};
			if (rst_sync[1] == rst_sync[2])
				bus_rst_lvl <= rst_sync[2];
		end
	end
	assign bus_rst_evt = (rst_sync[1] == rst_sync[2]) & rst_sync[2] & ~bus_rst_lvl;

	// =====================================================================
	// parity on both directions
	scsis_parity u_par
	(
		.tx_byte(tx_data),
		.rx_byte(rx_data),
		.rx_par(rx_par),
		.check_en(ctrl[`SCSIS_C_PCHK]),
		.tx_par(par_gen),
		.rx_err(par_err)
	);

	// outgoing byte and its parity, always generated
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_bus_data <= 8'h00;
			tx_bus_par <= 1'b1;
		end
		else
		begin
			tx_bus_data <= tx_data;
			tx_bus_par <= par_gen;
		end
	end

	// =====================================================================
	// configuration bits; the soft reset bit acts once and is not stored
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl <= `SCSIS_CTRL_RST;
		else if (wr_hit(`SCSIS_A_CTRL))
			ctrl <= {reg_wdata[`SCSIS_C_SYNC], reg_wdata[`SCSIS_C_PCHK], 1'b0};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_mask <= '0;
		else if (wr_hit(`SCSIS_A_INT_MASK))
			int_mask <= reg_wdata[`SCSIS_INT_W-1:0];
	end

	// =====================================================================
	// sequencer: arbitration, selection, messages, linking, scan
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= SCSIS_IDLE;
			ccb <= 27'h0;
			chain_defer <= 1'b0;
			scan_tgt <= 3'h0;
			present <= '0;
			arb_req <= 1'b0;
			sel_target <= 3'h0;
			ccb_fetch <= 1'b0;
			ccb_fetch_addr <= 24'h0;
			mbi_valid <= 1'b0;
			mailbox_in_entry <= '0;
			cmd_issue <= 1'b0;
			cmd <= '0;
			reject_out <= 1'b0;
		end
		else
		begin
			ccb_fetch <= 1'b0;
			mbi_valid <= 1'b0;
			cmd_issue <= 1'b0;
			reject_out <= 1'b0;
			if (wr_hit(`SCSIS_A_CCB))
				ccb <= reg_wdata[26:0];
			if (srst_req)
			begin
				// abandon everything, no diagnostics
				state <= SCSIS_IDLE;
				arb_req <= 1'b0;
				chain_defer <= 1'b0;
				present <= '0;
			end
			else if (bus_rst_evt)
			begin
				// soft handling: drop the bus, keep configuration
				state <= SCSIS_IDLE;
				arb_req <= 1'b0;
				chain_defer <= 1'b0;
			end
			else
			begin
				case (state)
					SCSIS_IDLE:
					begin
						if (start_req)
						begin
							state <= SCSIS_ARB;
							arb_req <= 1'b1;
							sel_target <= ccb[`SCSIS_CCB_TGT];
						end
						else if (scan_req)
						begin
							state <= SCSIS_SCAN;
							scan_tgt <= 3'h0;
							present <= '0;
						end
					end
					SCSIS_ARB:
					begin
						if (arb_won)
						begin
							state <= SCSIS_SEL;
							arb_req <= 1'b0;
						end
					end
					SCSIS_SEL:
					begin
						if (sel_done)
							state <= SCSIS_CONN;
					end
					SCSIS_CONN:
					begin
						if (msg_valid)
						begin
							case (msg.code)
								`SCSIS_M_CC:
								begin
									mbi_valid <= 1'b1;
									mailbox_in_entry <= '{status: cmd_status, addr: ccb[`SCSIS_CCB_ADR]};
									chain_defer <= 1'b0;
									state <= SCSIS_IDLE;
								end
								`SCSIS_M_LNK, `SCSIS_M_LNKF:
								begin
									// post the finished block, fetch the next one
									mbi_valid <= 1'b1;
									mailbox_in_entry <= '{status: cmd_status, addr: ccb[`SCSIS_CCB_ADR]};
									ccb_fetch <= 1'b1;
									ccb_fetch_addr <= ccb_link_ptr;
									ccb[`SCSIS_CCB_ADR] <= ccb_link_ptr;
									chain_defer <= (msg.code == `SCSIS_M_LNK);
								end
								`SCSIS_M_DISC:
									state <= SCSIS_DISC;
								`SCSIS_M_SDP, `SCSIS_M_EXT, `SCSIS_M_REJ:
								begin
									// handled by pointer, negotiation and interrupt flag logic
								end
								default:
								begin
									if (!msg.code[`SCSIS_M_IDENT])
										reject_out <= 1'b1;
								end
							endcase
						end
					end
					SCSIS_DISC:
					begin
						// reselection announces itself with an identify
						if (msg_valid && msg.code[`SCSIS_M_IDENT])
							state <= SCSIS_CONN;
					end
					SCSIS_SCAN:
					begin
						cmd_issue <= 1'b1;
						cmd <= '{target: scan_tgt, opcode: `SCSIS_OP_TUR};
						state <= SCSIS_SWAIT;
					end
					SCSIS_SWAIT:
					begin
						if (cmd_done)
						begin
							present[scan_tgt] <= cmd_ok;
							scan_tgt <= scan_tgt + 3'h1;
							state <= (scan_tgt == 3'(TARGETS - 1)) ? SCSIS_IDLE : SCSIS_SCAN;
						end
					end
					default:
						state <= SCSIS_IDLE;
				endcase
			end
		end
	end

	// =====================================================================
	// data pointer: host load, save, and signed modification
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dptr <= 32'h0;
			saved_ptr <= 32'h0;
		end
		else if (srst_req)
		begin
			dptr <= 32'h0;
			saved_ptr <= 32'h0;
		end
		else if (wr_hit(`SCSIS_A_DPTR))
			dptr <= reg_wdata;
		else if (state == SCSIS_CONN && msg_valid)
		begin
			if (msg.code == `SCSIS_M_SDP)
				saved_ptr <= dptr;
			else if (msg.code == `SCSIS_M_EXT && msg.ext == `SCSIS_X_MDP)
				dptr <= 32'(dptr + msg.arg);
		end
	end

	// =====================================================================
	// synchronous negotiation: accept any time, start when needed
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			negotiated <= '0;
			sdtr_reply <= 1'b0;
			sdtr_start <= 1'b0;
		end
		else
		begin
			sdtr_reply <= 1'b0;
			sdtr_start <= 1'b0;
			if (srst_req || bus_rst_evt)
				negotiated <= '0;
			else if (msg_valid && msg.code == `SCSIS_M_EXT && msg.ext == `SCSIS_X_SDTR)
			begin
				sdtr_reply <= 1'b1;
				negotiated[sel_target] <= 1'b1;
			end
			else if (state == SCSIS_SEL && sel_done && ctrl[`SCSIS_C_SYNC]
				&& !negotiated[sel_target])
			begin
				sdtr_start <= 1'b1;
				negotiated[sel_target] <= 1'b1;
			end
		end
	end

	// =====================================================================
	// interrupt flags: set wins over a write-one clear
	always_comb
	begin
		int_set = '0;
		int_set[`SCSIS_I_BRST] = bus_rst_evt;
		int_set[`SCSIS_I_PERR] = rx_valid & par_err;
		int_set[`SCSIS_I_REJ] = state == SCSIS_CONN && msg_valid && msg.code == `SCSIS_M_REJ;
		int_set[`SCSIS_I_SCAN] = state == SCSIS_SWAIT && cmd_done
			&& scan_tgt == 3'(TARGETS - 1);
		// full-mailbox interrupt on final completion or flagged link only
		int_set[`SCSIS_I_MAILBOX_IN_FULL_INTERRUPT] = state == SCSIS_CONN && msg_valid && !srst_req
			&& !bus_rst_evt && (msg.code == `SCSIS_M_CC || msg.code == `SCSIS_M_LNKF);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_stat <= '0;
		else if (srst_req)
			int_stat <= int_set & ~(`SCSIS_INT_W'(1) << `SCSIS_I_MAILBOX_IN_FULL_INTERRUPT);
		else
			int_stat <= (int_stat & ~int_clr) | int_set;
	end

	assign irq = |(int_stat & int_mask);

	// =====================================================================
	// register read, data one cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h0;
		else if (reg_rd)
		begin
			case (reg_addr)
				`SCSIS_A_CTRL: reg_rdata <= 32'({ctrl});
				`SCSIS_A_STATUS: reg_rdata <= 32'({chain_defer, bus_rst_lvl, state});
				`SCSIS_A_INT_STAT: reg_rdata <= 32'(int_stat);
				`SCSIS_A_INT_MASK: reg_rdata <= 32'(int_mask);
				`SCSIS_A_DPTR: reg_rdata <= dptr;
				`SCSIS_A_CCB: reg_rdata <= 32'(ccb);
				`SCSIS_A_SCAN: reg_rdata <= 32'(present);
				`SCSIS_A_NEG: reg_rdata <= 32'({saved_ptr[15:0], negotiated});
				default: reg_rdata <= 32'h0;
			endcase
		end
		else
			reg_rdata <= 32'h0;
	end
endmodule
